/* logic/sic_ctrl.sv */
// Seven-source prioritised nested interrupt controller, top level.
// Assumes the core takes the jump pulse at once and pulses reti at each routine end.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module sic_ctrl #(
   parameter int LAT_CYC = sic_pkg::LAT_MIN_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   input wire logic ext_irq_pin_a_n,
   input wire logic ext_irq_pin_b_n,
   input wire sic_pkg::sic_src_evt_t src_evt,
   input wire sic_pkg::sic_sync_in_t sync_in,
   input wire logic reti,
   output sic_pkg::sic_jump_t jump,
   output logic irq_out
);

   localparam int LAT_HI_I = sic_pkg::LAT_MAX_CYC;
   localparam int NS = sic_pkg::NUM_SRC;

   logic [7:0] irq_enable_q;
   logic [7:0] prio_lo_q;
   logic [7:0] prio_hi_q;
   logic [7:0] evt_status_q;
   logic [7:0] evt_mask_q;
   logic [7:0] rdata_q;
   logic [sic_pkg::EXT_W-1:0] ext_mode_q;
   logic [sic_pkg::SRC_SYNC-1:0] pend_lo_q;
   logic [sic_pkg::SRC_SYNC-1:0] pend_lo_d;
   logic adc_pend_q;
   logic pin_a_q;
   logic pin_b_q;
   logic [sic_pkg::NUM_LVL-1:0] active_q;
   logic [sic_pkg::NUM_LVL-1:0] active_d;
   logic [sic_pkg::NUM_LVL-1:0] hi_onehot;
   logic [sic_pkg::LVL_W-1:0] cur_lvl;
   logic [sic_pkg::CNT_W-1:0] cnt_q;
   logic [sic_pkg::SRC_W-1:0] win_src_q;
   logic [sic_pkg::SRC_W-1:0] best_src;
   logic [sic_pkg::LVL_W-1:0] best_lvl;
   logic best_found;
   logic [NS-1:0][sic_pkg::LVL_W-1:0] lvl;
   logic [NS-1:0] req_vec;
   logic [NS-1:0] eligible;
   logic [7:0] acq_reg;
   logic [7:0] disp_reg;
   logic [7:0] acq_reg_q;
   logic [7:0] disp_reg_q;
   logic sync_req;
   logic still_ok;
   logic accept;
   logic tie_lower;
   sic_pkg::sic_state_t state_q;
   sic_pkg::sic_jump_t jump_q;

   // ==========================================================================
   // Address decode
   logic wr_ie, wr_plo, wr_phi, wr_req, wr_mask, wr_ext, wr_acq, wr_disp, rd_stat;
   assign wr_ie = wr_en && (addr == sic_pkg::OFF_IRQ_ENABLE);
   assign wr_plo = wr_en && (addr == sic_pkg::OFF_PRIO_LO);
   assign wr_phi = wr_en && (addr == sic_pkg::OFF_PRIO_HI);
   assign wr_req = wr_en && (addr == sic_pkg::OFF_SRC_REQUEST);
   assign wr_mask = wr_en && (addr == sic_pkg::OFF_EVT_MASK);
   assign wr_ext = wr_en && (addr == sic_pkg::OFF_EXT_MODE);
   assign wr_acq = wr_en && (addr == sic_pkg::OFF_ACQ_SYNC);
   assign wr_disp = wr_en && (addr == sic_pkg::OFF_DISP_SYNC);
   assign rd_stat = rd_en && (addr == sic_pkg::OFF_EVT_STATUS);

   // ==========================================================================
   // Sync request group
   sic_sync_flags u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .sync_in(sync_in),
      .acq_wr(wr_acq),
      .disp_wr(wr_disp),
      .wdata(wdata),
      .acq_reg(acq_reg),
      .disp_reg(disp_reg),
      .sync_req(sync_req)
   );

   // Plain aliases of the flag images; the read mux below registers them
   assign acq_reg_q = acq_reg;
   assign disp_reg_q = disp_reg;

   // ==========================================================================
   // Configuration registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_enable_q <= sic_pkg::RST_BYTE;
         prio_lo_q <= sic_pkg::RST_BYTE;
         prio_hi_q <= sic_pkg::RST_BYTE;
         evt_mask_q <= sic_pkg::RST_BYTE;
         ext_mode_q <= '0;
      end else begin
         if (wr_ie) irq_enable_q <= wdata;
         if (wr_plo) prio_lo_q <= wdata;
         if (wr_phi) prio_hi_q <= wdata;
         if (wr_mask) evt_mask_q <= wdata;
         if (wr_ext) ext_mode_q <= wdata[sic_pkg::EXT_W-1:0];
      end
   end

   // ==========================================================================
   // Request flags; a hardware set wins over a same-cycle software clear
   logic [sic_pkg::SRC_SYNC-1:0] hw_set, hw_clr, lvl_mode, lvl_val;
   assign hw_set = {src_evt.ser_rx_done | src_evt.ser_tx_done, src_evt.tmr1_ovf,
                    pin_b_q & ~ext_irq_pin_b_n, src_evt.tmr0_ovf,
                    pin_a_q & ~ext_irq_pin_a_n};
   assign lvl_mode = {1'b0, 1'b0, ~ext_mode_q[1], 1'b0, ~ext_mode_q[0]};
   assign lvl_val = {1'b0, 1'b0, ~ext_irq_pin_b_n, 1'b0, ~ext_irq_pin_a_n};

   // Serial flag is left for software, like the receive and transmit flags it mirrors
   always_comb begin
      for (int i = 0; i < sic_pkg::SRC_SYNC; i++) begin
         hw_clr[i] = accept && (win_src_q == sic_pkg::SRC_W'(i)) && (i != sic_pkg::SRC_SERIAL);
         if (lvl_mode[i]) begin
            pend_lo_d[i] = lvl_val[i];
         end else begin
            pend_lo_d[i] = hw_set[i] | (wr_req ? wdata[i] : (pend_lo_q[i] & ~hw_clr[i]));
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pend_lo_q <= '0;
         adc_pend_q <= 1'b0;
         pin_a_q <= 1'b1;
         pin_b_q <= 1'b1;
      end else begin
         pend_lo_q <= pend_lo_d;
         adc_pend_q <= src_evt.adc_done | (wr_req ? wdata[sic_pkg::SRC_ADC] : adc_pend_q);
         pin_a_q <= ext_irq_pin_a_n;
         pin_b_q <= ext_irq_pin_b_n;
      end
   end

   // Seven request lines in vector order
   assign req_vec = {adc_pend_q, sync_req, pend_lo_q};

   // ==========================================================================
   // Current service level: highest set bit of the active stack
   always_comb begin
      cur_lvl = '0;
      for (int l = 0; l < sic_pkg::NUM_LVL; l++) begin
         if (active_q[l]) cur_lvl = sic_pkg::LVL_W'(l);
      end
      hi_onehot = (active_q != '0) ? (sic_pkg::NUM_LVL'(1) << cur_lvl) : '0;
   end

   // ==========================================================================
   // Eligibility and arbitration
   always_comb begin
      best_found = 1'b0;
      best_src = '0;
      best_lvl = '0;
      for (int i = 0; i < NS; i++) begin
         lvl[i] = {prio_hi_q[i], prio_lo_q[i]};
         eligible[i] = req_vec[i] && irq_enable_q[i]
                       && irq_enable_q[sic_pkg::GLOBAL_EN_BIT]
                       && ((active_q == '0) || (lvl[i] > cur_lvl));
      end
      // Descending scan with >= lets the lowest index win a tie
      for (int i = NS - 1; i >= 0; i--) begin
         if (eligible[i] && (!best_found || lvl[i] >= best_lvl)) begin
            best_found = 1'b1;
            best_src = sic_pkg::SRC_W'(i);
            best_lvl = lvl[i];
         end
      end
   end

   // Tie check helper for the ordering assertion
   always_comb begin
      tie_lower = 1'b0;
      for (int i = 0; i < NS; i++) begin
         if (eligible[i] && (sic_pkg::SRC_W'(i) < best_src) && (lvl[i] >= best_lvl)) begin
            tie_lower = 1'b1;
         end
      end
   end

   assign still_ok = eligible[win_src_q];
   assign accept = (state_q == sic_pkg::SIC_WAIT) && still_ok
                   && (cnt_q == sic_pkg::CNT_W'(LAT_CYC - 1));

   // ==========================================================================
   // Dispatch sequencer; the winner is fixed for the wait, a cancelled one aborts
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q <= sic_pkg::SIC_IDLE;
         cnt_q <= '0;
         win_src_q <= '0;
      end else begin
         unique case (state_q)
            sic_pkg::SIC_IDLE: begin
               cnt_q <= '0;
               if (best_found) begin
                  win_src_q <= best_src;
                  state_q <= sic_pkg::SIC_WAIT;
               end
            end
            sic_pkg::SIC_WAIT: begin
               if (!still_ok) begin
                  state_q <= sic_pkg::SIC_IDLE;
               end else if (accept) begin
                  state_q <= sic_pkg::SIC_JUMP;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            sic_pkg::SIC_JUMP: begin
               state_q <= sic_pkg::SIC_IDLE;
            end
            default: begin
               state_q <= sic_pkg::SIC_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // Jump output to the core; fields hold after the one-cycle valid
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         jump_q <= '0;
      end else begin
         jump_q.valid <= accept;
         if (accept) begin
            jump_q.src <= win_src_q;
            jump_q.level <= lvl[win_src_q];
            jump_q.vector <= sic_pkg::VECTOR_TABLE[win_src_q];
         end
      end
   end
   assign jump = jump_q;

   // ==========================================================================
   // Active level stack; release precedes a new entry in the same cycle
   always_comb begin
      active_d = active_q;
      if (reti) active_d = active_d & ~hi_onehot;
      if (accept) active_d = active_d | (sic_pkg::NUM_LVL'(1) << lvl[win_src_q]);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         active_q <= '0;
      end else begin
         active_q <= active_d;
      end
   end

   // ==========================================================================
   // Sticky acceptance events, cleared by read; a new event wins over the clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         evt_status_q <= sic_pkg::RST_BYTE;
      end else begin
         evt_status_q <= (rd_stat ? sic_pkg::RST_BYTE : evt_status_q)
                         | (accept ? (8'h01 << win_src_q) : sic_pkg::RST_BYTE);
      end
   end

   assign irq_out = |(evt_status_q & evt_mask_q);

   // ==========================================================================
   // Read data, one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata_q <= sic_pkg::RST_BYTE;
      end else if (rd_en) begin
         unique case (addr)
            sic_pkg::OFF_IRQ_ENABLE: rdata_q <= irq_enable_q;
            sic_pkg::OFF_PRIO_LO: rdata_q <= {1'b0, prio_lo_q[NS-1:0]};
            sic_pkg::OFF_PRIO_HI: rdata_q <= {1'b0, prio_hi_q[NS-1:0]};
            sic_pkg::OFF_ACQ_SYNC: rdata_q <= acq_reg_q;
            sic_pkg::OFF_DISP_SYNC: rdata_q <= disp_reg_q;
            sic_pkg::OFF_SRC_REQUEST: rdata_q <= {1'b0, req_vec};
            sic_pkg::OFF_CTRL_STATUS: rdata_q <= {state_q != sic_pkg::SIC_IDLE,
                                                  jump_q.src, active_q};
            sic_pkg::OFF_EVT_STATUS: rdata_q <= evt_status_q;
            sic_pkg::OFF_EVT_MASK: rdata_q <= evt_mask_q;
            sic_pkg::OFF_EXT_MODE: rdata_q <= {6'h00, ext_mode_q};
            default: rdata_q <= sic_pkg::RST_BYTE;
         endcase
      end else begin
         rdata_q <= sic_pkg::RST_BYTE;
      end
   end
   assign rdata = rdata_q;

   // ==========================================================================
   // Checks
   a_global_gate: assert property (@(posedge clk) disable iff (!reset_n)
      jump_q.valid |-> $past(irq_enable_q[sic_pkg::GLOBAL_EN_BIT]))
      else $error("jump taken while global enable low");

   a_global_blocks: assert property (@(posedge clk) disable iff (!reset_n)
      !irq_enable_q[sic_pkg::GLOBAL_EN_BIT] [*2] |-> !accept)
      else $error("accept with global enable low");

   a_source_enable: assert property (@(posedge clk) disable iff (!reset_n)
      jump_q.valid |-> $past(irq_enable_q[win_src_q]) && $past(req_vec[win_src_q]))
      else $error("jump for a disabled or idle source");

   a_vector_ext_a: assert property (@(posedge clk) disable iff (!reset_n)
      jump_q.valid && (jump_q.src == sic_pkg::SRC_W'(sic_pkg::SRC_EXT_A))
      |-> jump_q.vector == sic_pkg::VEC_EXT_A)
      else $error("wrong vector for pin A");

   a_vector_serial: assert property (@(posedge clk) disable iff (!reset_n)
      jump_q.valid && (jump_q.src == sic_pkg::SRC_W'(sic_pkg::SRC_SERIAL))
      |-> jump_q.vector == sic_pkg::VEC_SERIAL)
      else $error("wrong vector for serial");

   a_vector_adc: assert property (@(posedge clk) disable iff (!reset_n)
      jump_q.valid && (jump_q.src == sic_pkg::SRC_W'(sic_pkg::SRC_ADC))
      |-> jump_q.vector == sic_pkg::VEC_ADC)
      else $error("wrong vector for ADC");

   a_latency_bound: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(state_q == sic_pkg::SIC_WAIT) |-> ##[1:LAT_HI_I] (state_q != sic_pkg::SIC_WAIT))
      else $error("dispatch wait too long");

   a_latency_floor: assert property (@(posedge clk) disable iff (!reset_n)
      jump_q.valid |-> $past(cnt_q) == sic_pkg::CNT_W'(LAT_CYC - 1))
      else $error("dispatch wait too short");

   a_nest_above: assert property (@(posedge clk) disable iff (!reset_n)
      jump_q.valid |-> ($past(active_q) == '0) || (jump_q.level > $past(cur_lvl)))
      else $error("jump without pre-empting level");

   a_tie_order: assert property (@(posedge clk) disable iff (!reset_n)
      (state_q == sic_pkg::SIC_IDLE) && best_found |-> !tie_lower)
      else $error("tie not given to lowest index");

   a_sw_request: assert property (@(posedge clk) disable iff (!reset_n)
      wr_req && !src_evt.tmr0_ovf && !accept
      |=> pend_lo_q[sic_pkg::SRC_TMR0] == $past(wdata[sic_pkg::SRC_TMR0]))
      else $error("software request write lost");

   a_reti_release: assert property (@(posedge clk) disable iff (!reset_n)
      reti && (active_q != '0) && !accept |=> $countones(active_q) < $countones($past(active_q)))
      else $error("routine end did not release level");

endmodule : sic_ctrl

/* pkg/sic_pkg.sv */
// Shared constants, types and register map of the seven-source interrupt controller.
// Assumes one core clock domain and an 8-bit register port with registered read data.
package sic_pkg;

   // ==========================================================================
   // Sizes
   localparam int NUM_SRC = 7;
   localparam int NUM_LVL = 4;
   localparam int LVL_W = 2;
   localparam int SRC_W = 3;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int NUM_SYNC = 6;
   localparam int ACQ_FLAGS = 4;
   localparam int FLAG_STRIDE = 2;
   localparam int EN_OFS = 1;
   localparam int CNT_W = 9;
   localparam int EXT_W = 2;

   // ==========================================================================
   // Register offsets
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'ha8;
   localparam logic [7:0] OFF_PRIO_LO = 8'ha9;
   localparam logic [7:0] OFF_PRIO_HI = 8'haa;
   localparam logic [7:0] OFF_ACQ_SYNC = 8'hc0;
   localparam logic [7:0] OFF_DISP_SYNC = 8'hc8;
   localparam logic [7:0] OFF_SRC_REQUEST = 8'hb8;
   localparam logic [7:0] OFF_CTRL_STATUS = 8'hb9;
   localparam logic [7:0] OFF_EVT_STATUS = 8'hba;
   localparam logic [7:0] OFF_EVT_MASK = 8'hbb;
   localparam logic [7:0] OFF_EXT_MODE = 8'hbc;
   localparam logic [7:0] RST_BYTE = 8'h00;

   // ==========================================================================
   // Source indices, equal to their enable bit positions
   localparam int SRC_EXT_A = 0;
   localparam int SRC_TMR0 = 1;
   localparam int SRC_EXT_B = 2;
   localparam int SRC_TMR1 = 3;
   localparam int SRC_SERIAL = 4;
   localparam int SRC_SYNC = 5;
   localparam int SRC_ADC = 6;
   localparam int GLOBAL_EN_BIT = 7;
   localparam int BUSY_BIT = 7;

   // ==========================================================================
   // Vectors
   localparam logic [7:0] VEC_EXT_A = 8'h03;
   localparam logic [7:0] VEC_TMR0 = 8'h0b;
   localparam logic [7:0] VEC_EXT_B = 8'h13;
   localparam logic [7:0] VEC_TMR1 = 8'h1b;
   localparam logic [7:0] VEC_SERIAL = 8'h23;
   localparam logic [7:0] VEC_SYNC = 8'h2b;
   localparam logic [7:0] VEC_ADC = 8'h33;
   localparam logic [NUM_SRC-1:0][7:0] VECTOR_TABLE = {VEC_ADC, VEC_SYNC, VEC_SERIAL,
      VEC_TMR1, VEC_EXT_B, VEC_TMR0, VEC_EXT_A};

   // ==========================================================================
   // Timing
   localparam real CLK_PERIOD_NS = 8.0;
   localparam real LAT_MIN_US = 0.89;
   localparam real LAT_MAX_US = 2.33;
   localparam int LAT_MIN_CYC = int'($ceil(LAT_MIN_US * 1000.0 / CLK_PERIOD_NS));
   localparam int LAT_MAX_CYC = int'($floor(LAT_MAX_US * 1000.0 / CLK_PERIOD_NS));

   // ==========================================================================
   // Types
   typedef enum logic [1:0] {
      SIC_IDLE = 2'b00,
      SIC_WAIT = 2'b01,
      SIC_JUMP = 2'b10
   } sic_state_t;

   typedef struct packed {
      logic disp_vsync;
      logic disp_hsync;
      logic acq_even;
      logic acq_line24;
      logic acq_vsync;
      logic acq_hsync;
   } sic_sync_in_t;

   typedef struct packed {
      logic tmr0_ovf;
      logic tmr1_ovf;
      logic ser_rx_done;
      logic ser_tx_done;
      logic adc_done;
   } sic_src_evt_t;

   typedef struct packed {
      logic valid;
      logic [SRC_W-1:0] src;
      logic [LVL_W-1:0] level;
      logic [7:0] vector;
   } sic_jump_t;

endpackage : sic_pkg

/* logic/sic_sync_flags.sv */
// Sync request flag group: acquisition and display sync request registers.
// Assumes sync inputs are synchronous to clk and held at least one cycle high.
`timescale 1ns/10ps
module sic_sync_flags (
   input wire logic clk,
   input wire logic reset_n,
   input wire sic_pkg::sic_sync_in_t sync_in,
   input wire logic acq_wr,
   input wire logic disp_wr,
   input wire logic [7:0] wdata,
   output logic [7:0] acq_reg,
   output logic [7:0] disp_reg,
   output logic sync_req
);

   logic [sic_pkg::NUM_SYNC-1:0] sync_bits;
   logic [sic_pkg::NUM_SYNC-1:0] prev_q;
   logic [sic_pkg::NUM_SYNC-1:0] flag_q;
   logic [sic_pkg::NUM_SYNC-1:0] en_q;

   assign sync_bits = sync_in;

   // ==========================================================================
   // Previous sample for rising edge detection
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prev_q <= '0;
      end else begin
         prev_q <= sync_bits;
      end
   end

   // ==========================================================================
   // One flag and one enable per sync source
   genvar k;
   generate
      for (k = 0; k < sic_pkg::NUM_SYNC; k++) begin : g_flag
         localparam int FB = sic_pkg::FLAG_STRIDE * (k % sic_pkg::ACQ_FLAGS);
         localparam int EB = FB + sic_pkg::EN_OFS;
         logic wr;
         logic rise;
         assign wr = (k < sic_pkg::ACQ_FLAGS) ? acq_wr : disp_wr;
         assign rise = sync_bits[k] & ~prev_q[k];

         // Edge set beats a software clear in the same cycle
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               flag_q[k] <= 1'b0;
               en_q[k] <= 1'b0;
            end else begin
               flag_q[k] <= rise | (wr ? wdata[FB] : flag_q[k]);
               en_q[k] <= wr ? wdata[EB] : en_q[k];
            end
         end

         a_sync_edge_set: assert property (@(posedge clk) disable iff (!reset_n)
            rise |=> flag_q[k] [*2] or (flag_q[k] ##1 $past(wr)))
            else $error("sync flag not set by rising edge");
      end
   endgenerate

   // ==========================================================================
   // Register images; display bits above the group read zero
   always_comb begin
      acq_reg = '0;
      disp_reg = '0;
      for (int i = 0; i < sic_pkg::NUM_SYNC; i++) begin
         if (i < sic_pkg::ACQ_FLAGS) begin
            acq_reg[sic_pkg::FLAG_STRIDE * i] = flag_q[i];
            acq_reg[sic_pkg::FLAG_STRIDE * i + sic_pkg::EN_OFS] = en_q[i];
         end else begin
            disp_reg[sic_pkg::FLAG_STRIDE * (i - sic_pkg::ACQ_FLAGS)] = flag_q[i];
            disp_reg[sic_pkg::FLAG_STRIDE * (i - sic_pkg::ACQ_FLAGS) + sic_pkg::EN_OFS] =
               en_q[i];
         end
      end
   end

   // Any enabled flag raises the shared sync request
   assign sync_req = |(flag_q & en_q);

endmodule : sic_sync_flags

/* verif/sic_core_model.sv */
// Core stand-in: takes each jump and ends every routine after a fixed hold.
// Assumes jump.valid is a one-cycle pulse; a pre-empting routine ends first.
`timescale 1ns/10ps
module sic_core_model #(
   parameter int HOLD = 20
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire sic_pkg::sic_jump_t jump,
   output logic reti
);
   int cnt_q;
   int depth_q;
   // ==========================================================================
   // Routine end, innermost first, so every level gets released in turn
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_q <= 0;
         depth_q <= 0;
      end else if (jump.valid) begin
         depth_q <= depth_q + 1;
         cnt_q <= HOLD;
      end else if (cnt_q == 1) begin
         depth_q <= depth_q - 1;
         cnt_q <= (depth_q > 1) ? HOLD : 0;
      end else if (cnt_q != 0) begin
         cnt_q <= cnt_q - 1;
      end
   end
   // End pulse only from a running routine, never in a jump cycle
   always_ff @(posedge clk) begin
      reti <= reset_n && !jump.valid && (cnt_q == 1);
   end
endmodule : sic_core_model

/* verif/tb_seven_source_interrupt_controller.sv */
// Self-checking bench: register port tasks, core model, queued expectations.
// Assumes the controller is built with a short dispatch wait of 4 cycles.
`timescale 1ns/10ps
module tb_seven_source_interrupt_controller;
   logic clk = 0, reset_n = 0, wr_en = 0, rd_en = 0, rd_d = 0, reti;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   sic_pkg::sic_sync_in_t sync_in = '0;
   sic_pkg::sic_src_evt_t src_evt = '0;
   logic pin_a_n = 1'b1, pin_b_n = 1'b1;
   sic_pkg::sic_jump_t jump;
   logic irq_out;
   logic [7:0] rq[$], jq[$];
   logic [7:0] vec[7] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h33};
   logic [31:0] seed = 32'h3fa198ca;
   int error_cnt = 0, checks_done = 0;
   sic_ctrl #(.LAT_CYC(4)) dut_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ext_irq_pin_a_n(pin_a_n),
      .ext_irq_pin_b_n(pin_b_n), .src_evt(src_evt), .sync_in(sync_in), .reti(reti), .jump(jump),
      .irq_out(irq_out));
   sic_core_model #(.HOLD(20)) core_u (.clk(clk), .reset_n(reset_n), .jump(jump), .reti(reti));
   // ==========================================================================
   // Helpers
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk) {addr, wdata, wr_en} <= {a, d, 1'b1};
      @(posedge clk) wr_en <= 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] e);
      rq.push_back(e);
      @(posedge clk) {addr, rd_en} <= {a, 1'b1};
      @(posedge clk) rd_en <= 1'b0;
   endtask : rd
   task automatic wait_jump();
      for (int k = 0; k < 60 && jump.valid !== 1'b1; k++) @(posedge clk);
   endtask : wait_jump
   task automatic conclude();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // ==========================================================================
   // Clock, watchdog and result monitor
   initial forever #4 clk = ~clk;
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      conclude();
   end
   // Read data only stands one cycle after the strobe, so it is taken there
   always @(posedge clk) begin
      rd_d <= rd_en;
      if (rd_d) chk(rdata, rq.pop_front());
      if (jump.valid === 1'b1) begin
         chk(jump.vector, vec[jump.src]);
         if (jq.size() == 0) chk(jump.vector, 8'hee);
         else chk(jump.vector, jq.pop_front());
      end
   end
   // ==========================================================================
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'ha8, 8'h00);
      rd(8'hc0, 8'h00);
      rd(8'hc8, 8'h00);
      rd(8'hff, 8'h00);
      seed = lfsr(seed);
      wr(8'ha9, seed[7:0]);
      rd(8'ha9, seed[7:0] & 8'h7f);
      wr(8'ha9, 8'h00);
      wr(8'hbc, 8'h03);
      wr(8'hbb, 8'hff);
      // Every source in turn, one vector each
      for (int i = 0; i < 7; i++) begin
         wr(8'ha8, 8'h80 | (8'h01 << i));
         jq.push_back(vec[i]);
         if (i == 5) begin
            wr(8'hc8, 8'h02);
            @(posedge clk) sync_in <= 6'h10;
            @(posedge clk) sync_in <= 6'h00;
            rd(8'hc8, 8'h03);
         end else begin
            wr(8'hb8, 8'h01 << i);
         end
         wait_jump();
         @(posedge clk);
         chk(irq_out, 1'b1);
         wr(8'hb8, 8'h00);
         wr(8'hc8, 8'h00);
         rd(8'hba, 8'h01 << i);
         @(posedge clk);
         chk(irq_out, 1'b0);
         repeat (40) @(posedge clk);
      end
      // Global enable low holds a request off until it rises
      wr(8'ha8, 8'h01);
      wr(8'hb8, 8'h01);
      repeat (30) @(posedge clk);
      jq.push_back(8'h03);
      wr(8'ha8, 8'h81);
      repeat (40) @(posedge clk);
      // Hardware events: pin A falling edge, timer 0 pulse, pin B low in level mode
      jq.push_back(8'h03);
      @(posedge clk) pin_a_n <= 1'b0;
      repeat (40) @(posedge clk);
      pin_a_n <= 1'b1;
      wr(8'ha8, 8'h82);
      jq.push_back(8'h0b);
      @(posedge clk) src_evt <= 5'h10;
      @(posedge clk) src_evt <= 5'h00;
      repeat (40) @(posedge clk);
      wr(8'hbc, 8'h01);
      wr(8'ha8, 8'h84);
      jq.push_back(8'h13);
      @(posedge clk) pin_b_n <= 1'b0;
      repeat (15) @(posedge clk);
      pin_b_n <= 1'b1;
      repeat (40) @(posedge clk);
      // Pin A wins the level-0 tie over timer 0, then timer 1 at top level pre-empts it
      wr(8'ha9, 8'h08);
      wr(8'haa, 8'h08);
      wr(8'ha8, 8'h8b);
      jq.push_back(8'h03);
      jq.push_back(8'h1b);
      jq.push_back(8'h0b);
      wr(8'hb8, 8'h03);
      repeat (10) @(posedge clk);
      wr(8'hb8, 8'h0a);
      repeat (150) @(posedge clk);
      chk(8'(jq.size()), 8'h00);
      conclude();
   end
endmodule : tb_seven_source_interrupt_controller
